// file: logic/rft3_pkg.sv
// Package for the reader front end timer three: map, fields, encodings
package rft3_pkg;

  // Register byte offsets
  localparam logic [7:0] RFT3_OFS_CTRL      = 8'h1E;
  localparam logic [7:0] RFT3_OFS_RELOAD_HI = 8'h1F;
  localparam logic [7:0] RFT3_OFS_RELOAD_LO = 8'h20;
  localparam logic [7:0] RFT3_OFS_COUNT_HI  = 8'h21;
  localparam logic [7:0] RFT3_OFS_COUNT_LO  = 8'h22;

  // Control register field positions
  localparam int RFT3_CTRL_STOP_RX_BIT = 7;
  localparam int RFT3_CTRL_START_LSB   = 4;
  localparam int RFT3_CTRL_AUTO_BIT    = 3;
  localparam int RFT3_CTRL_CLK_LSB     = 0;

  // Reset values
  localparam logic [7:0]  RFT3_CTRL_RST   = 8'h00;
  localparam logic [7:0]  RFT3_RELOAD_RST = 8'h00;
  localparam logic [15:0] RFT3_COUNT_RST  = 16'h0000;
  localparam logic [7:0]  RFT3_RDATA_RST  = 8'h00;

  // Nominal rates of the two fixed count clocks, for reference only
  localparam int RFT3_FAST_CLK_KHZ_X100 = 1356000;
  localparam int RFT3_SLOW_CLK_HZ       = 211875;

  // Start source selection
  typedef enum logic [1:0] {
    RFT3_START_NONE     = 2'b00,
    RFT3_START_TX_END   = 2'b01,
    RFT3_START_TRIM     = 2'b10,
    RFT3_START_TRIM_UF  = 2'b11
  } rft3_start_t;

  // Count clock selection
  typedef enum logic [1:0] {
    RFT3_CLK_FAST  = 2'b00,
    RFT3_CLK_SLOW  = 2'b01,
    RFT3_CLK_TZERO = 2'b10,
    RFT3_CLK_TONE  = 2'b11
  } rft3_clksel_t;

endpackage

// file: logic/rft3_timer.sv
// Reader front end timer three: 16-bit down counter with byte registers
module rft3_timer (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Count clock ticks, one cycle each
  input  wire logic        tick_fast_i,
  input  wire logic        tick_slow_i,
  input  wire logic        timer_zero_uf_i,
  input  wire logic        timer_one_uf_i,
  // Start and stop events from the transceiver
  input  wire logic        start_now_i,
  input  wire logic        tx_end_i,
  input  wire logic        rx_four_bits_i,
  input  wire logic        trim_rise_i,
  // Status out
  output logic             running_o,
  output logic             underflow_o,
  output logic             underflow_irq_flag_o
);
  import rft3_pkg::*;

  typedef struct packed {
    logic         stop_on_receive;
    rft3_start_t  start_select;
    logic         auto_reload_enable;
    rft3_clksel_t count_clock_select;
    logic [7:0]   reload_value_high;
    logic [7:0]   reload_value_low;
    logic [15:0]  count;
    logic         running;
    logic         irq;
    logic [7:0]   rdata;
  } rft3_state_t;

  rft3_state_t s_q, s_d;
  logic        tick;
  logic        uf;
  logic        start_evt;
  logic        rx_stop;
  logic        trim_mode;
  logic [15:0] reload_value;

  // Chosen count clock tick
  function automatic logic pick_tick(input rft3_clksel_t sel,
                                     input logic [3:0] ticks);
    unique case (sel)
      RFT3_CLK_FAST:  pick_tick = ticks[0];
      RFT3_CLK_SLOW:  pick_tick = ticks[1];
      RFT3_CLK_TZERO: pick_tick = ticks[2];
      RFT3_CLK_TONE:  pick_tick = ticks[3];
    endcase
  endfunction

  // Event decode
  always_comb begin
    reload_value = {s_q.reload_value_high, s_q.reload_value_low};
    tick = pick_tick(s_q.count_clock_select,
                     {timer_one_uf_i, timer_zero_uf_i,
                      tick_slow_i, tick_fast_i});
    trim_mode = s_q.start_select[1];
    // Trimming starts on an oscillator rise while idle, stops on the next
    start_evt = start_now_i
              | (tx_end_i & (s_q.start_select == RFT3_START_TX_END))
              | (trim_rise_i & trim_mode & ~s_q.running);
    // Trim modes mask the receive stop
    rx_stop = rx_four_bits_i & s_q.stop_on_receive & ~trim_mode;
    // No underflow in plain trimming: the count just parks at zero
    uf = s_q.running & tick & (s_q.count == 16'h0000)
       & (s_q.start_select != RFT3_START_TRIM);
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.irq = uf;
    // Register writes; reserved control bits are dropped
    if (wr_i) begin
      unique case (addr_i)
        RFT3_OFS_CTRL: begin
          s_d.stop_on_receive    = wdata_i[RFT3_CTRL_STOP_RX_BIT];
          s_d.start_select       =
            rft3_start_t'(wdata_i[RFT3_CTRL_START_LSB +: 2]);
          s_d.auto_reload_enable = wdata_i[RFT3_CTRL_AUTO_BIT];
          s_d.count_clock_select =
            rft3_clksel_t'(wdata_i[RFT3_CTRL_CLK_LSB +: 2]);
        end
        RFT3_OFS_RELOAD_HI: s_d.reload_value_high = wdata_i;
        RFT3_OFS_RELOAD_LO: s_d.reload_value_low  = wdata_i;
        default: ;
      endcase
    end
    // Counting; a start wins over a stop in the same cycle
    if (start_evt) begin
      s_d.count   = reload_value;
      s_d.running = 1'b1;
    end else if (rx_stop || (trim_rise_i && trim_mode && s_q.running)) begin
      s_d.running = 1'b0;
    end else if (uf) begin
      if (s_q.auto_reload_enable) begin
        s_d.count = reload_value;
      end else begin
        s_d.running = 1'b0;
      end
    end else if (s_q.running && tick && s_q.count != 16'h0000) begin
      s_d.count = s_q.count - 16'h0001;
    end
    // Read data stands in the cycle after the strobe only
    s_d.rdata = RFT3_RDATA_RST;
    if (rd_i) begin
      unique case (addr_i)
        RFT3_OFS_CTRL: begin
          s_d.rdata[RFT3_CTRL_STOP_RX_BIT]     = s_q.stop_on_receive;
          s_d.rdata[RFT3_CTRL_START_LSB +: 2]  = s_q.start_select;
          s_d.rdata[RFT3_CTRL_AUTO_BIT]        = s_q.auto_reload_enable;
          s_d.rdata[RFT3_CTRL_CLK_LSB +: 2]    = s_q.count_clock_select;
        end
        RFT3_OFS_RELOAD_HI: s_d.rdata = s_q.reload_value_high;
        RFT3_OFS_RELOAD_LO: s_d.rdata = s_q.reload_value_low;
        // Not stable during reception; software avoids that window
        RFT3_OFS_COUNT_HI:  s_d.rdata = s_q.count[15:8];
        RFT3_OFS_COUNT_LO:  s_d.rdata = s_q.count[7:0];
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q.stop_on_receive    <= RFT3_CTRL_RST[RFT3_CTRL_STOP_RX_BIT];
      s_q.start_select       <= RFT3_START_NONE;
      s_q.auto_reload_enable <= RFT3_CTRL_RST[RFT3_CTRL_AUTO_BIT];
      s_q.count_clock_select <= RFT3_CLK_FAST;
      s_q.reload_value_high  <= RFT3_RELOAD_RST;
      s_q.reload_value_low   <= RFT3_RELOAD_RST;
      s_q.count              <= RFT3_COUNT_RST;
      s_q.running            <= 1'b0;
      s_q.irq                <= 1'b0;
      s_q.rdata              <= RFT3_RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign rdata_o              = s_q.rdata;
  assign running_o            = s_q.running;
  assign underflow_o          = uf;
  assign underflow_irq_flag_o = s_q.irq;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_start_loads_reload: assert property (
    start_evt |=> running_o && s_q.count == $past(reload_value))
    else $error("start did not load reload value");

  a_rx_stop_halts: assert property (
    rx_stop && !start_evt |=> !running_o)
    else $error("receive stop did not halt timer");

  a_trim_ignores_rx: assert property (
    running_o && trim_mode && rx_four_bits_i && !trim_rise_i && !uf
    && !start_now_i |=> running_o)
    else $error("receive stop acted in trim mode");

  a_no_auto_start: assert property (
    !running_o && s_q.start_select == RFT3_START_NONE && !start_now_i
    |=> !running_o)
    else $error("timer started without a source");

  a_uf_reloads: assert property (
    uf && s_q.auto_reload_enable && !start_evt && !rx_stop
    && !(trim_rise_i && trim_mode)
    |=> running_o && s_q.count == $past(reload_value))
    else $error("auto reload failed");

  a_uf_stops: assert property (
    uf && !s_q.auto_reload_enable && !start_evt |=> !running_o ##1
    (!running_o || $past(start_evt)))
    else $error("timer kept running after underflow");

  a_uf_raises_irq: assert property (
    uf |=> underflow_irq_flag_o ##1 (underflow_irq_flag_o == $past(uf)))
    else $error("underflow did not raise request");

  a_fast_decrement: assert property (
    running_o && s_q.count_clock_select == RFT3_CLK_FAST && tick_fast_i
    && s_q.count != 16'h0000 && !start_evt && !rx_stop && !trim_rise_i
    |=> s_q.count == $past(s_q.count) - 16'h0001)
    else $error("selected clock did not decrement");

  a_reload_write_quiet: assert property (
    wr_i && (addr_i == RFT3_OFS_RELOAD_HI || addr_i == RFT3_OFS_RELOAD_LO)
    && !tick && !start_evt |=> $stable(s_q.count))
    else $error("reload write disturbed count");

  a_count_readback: assert property (
    rd_i && addr_i == RFT3_OFS_COUNT_HI |=> rdata_o == $past(s_q.count[15:8]))
    else $error("count high byte read wrong");

  a_rsvd_zero: assert property (
    rd_i && addr_i == RFT3_OFS_CTRL |=> rdata_o[6] == 1'b0
    && rdata_o[2] == 1'b0)
    else $error("reserved control bit read nonzero");

  // Register port: writes land, reads stand one cycle
  a_ctrl_write_lands: assert property (
    wr_i && addr_i == RFT3_OFS_CTRL
    |=> s_q.stop_on_receive == $past(wdata_i[RFT3_CTRL_STOP_RX_BIT])
    && s_q.start_select == $past(wdata_i[RFT3_CTRL_START_LSB +: 2])
    && s_q.auto_reload_enable == $past(wdata_i[RFT3_CTRL_AUTO_BIT])
    && s_q.count_clock_select == $past(wdata_i[RFT3_CTRL_CLK_LSB +: 2]))
    else $error("control write did not land");

  a_reload_hi_lands: assert property (
    wr_i && addr_i == RFT3_OFS_RELOAD_HI
    |=> s_q.reload_value_high == $past(wdata_i))
    else $error("reload high write did not land");

  a_reload_lo_lands: assert property (
    wr_i && addr_i == RFT3_OFS_RELOAD_LO
    |=> s_q.reload_value_low == $past(wdata_i))
    else $error("reload low write did not land");

  a_count_lo_readback: assert property (
    rd_i && addr_i == RFT3_OFS_COUNT_LO |=> rdata_o == $past(s_q.count[7:0]))
    else $error("count low byte read wrong");

  a_reload_hi_readback: assert property (
    rd_i && addr_i == RFT3_OFS_RELOAD_HI
    |=> rdata_o == $past(s_q.reload_value_high))
    else $error("reload high byte read wrong");

  a_reload_lo_readback: assert property (
    rd_i && addr_i == RFT3_OFS_RELOAD_LO
    |=> rdata_o == $past(s_q.reload_value_low))
    else $error("reload low byte read wrong");

  a_rdata_idle_zero: assert property (
    !rd_i |=> rdata_o == RFT3_RDATA_RST)
    else $error("read data stood past its cycle");

  a_unmapped_read_zero: assert property (
    rd_i && (addr_i < RFT3_OFS_CTRL || addr_i > RFT3_OFS_COUNT_LO)
    |=> rdata_o == RFT3_RDATA_RST)
    else $error("unmapped read returned data");

  a_count_read_only: assert property (
    wr_i && (addr_i == RFT3_OFS_COUNT_HI || addr_i == RFT3_OFS_COUNT_LO)
    && !tick && !start_evt |=> $stable(s_q.count))
    else $error("count byte write changed count");

  a_reload_write_counts: assert property (
    wr_i && (addr_i == RFT3_OFS_RELOAD_HI || addr_i == RFT3_OFS_RELOAD_LO)
    && running_o && tick && s_q.count != 16'h0000 && !start_evt
    && !rx_stop && !(trim_rise_i && trim_mode)
    |=> s_q.count == $past(s_q.count) - 16'h0001)
    else $error("reload write disturbed a running count");

  // Start sources, the trim window and the receive stop
  a_tx_end_starts: assert property (
    tx_end_i && s_q.start_select == RFT3_START_TX_END
    |=> running_o && s_q.count == $past(reload_value))
    else $error("transmit end did not start timer");

  a_trim_rise_starts: assert property (
    trim_rise_i && trim_mode && !running_o
    |=> running_o && s_q.count == $past(reload_value))
    else $error("trim rise did not start timer");

  a_trim_rise_stops: assert property (
    trim_rise_i && trim_mode && running_o && !start_now_i |=> !running_o)
    else $error("trim rise did not stop timer");

  a_trim_no_underflow: assert property (
    s_q.start_select == RFT3_START_TRIM |-> !underflow_o)
    else $error("underflow in plain trim mode");

  a_trim_parks_zero: assert property (
    running_o && s_q.start_select == RFT3_START_TRIM
    && s_q.count == 16'h0000 && !start_evt |=> s_q.count == 16'h0000)
    else $error("trim count left zero");

  a_rx_ignored_clear: assert property (
    running_o && rx_four_bits_i && !s_q.stop_on_receive && !uf
    && !start_evt && !(trim_rise_i && trim_mode) |=> running_o)
    else $error("receive stopped timer with stop clear");

  a_rx_stop_holds: assert property (
    rx_stop && !start_evt |=> $stable(s_q.count))
    else $error("receive stop moved the count");

  // Counting, stopping and the request pulse
  a_stopped_holds: assert property (
    !running_o && !start_evt |=> !running_o && $stable(s_q.count))
    else $error("stopped timer moved");

  a_uf_stop_zero: assert property (
    uf && !s_q.auto_reload_enable && !start_evt |=> s_q.count == 16'h0000)
    else $error("one-shot count left zero");

  a_irq_only_on_uf: assert property (
    underflow_irq_flag_o |-> $past(uf))
    else $error("request raised without underflow");

  a_no_uf_idle: assert property (
    !running_o |-> !underflow_o)
    else $error("underflow while stopped");

  a_slow_decrement: assert property (
    running_o && s_q.count_clock_select == RFT3_CLK_SLOW && tick_slow_i
    && s_q.count != 16'h0000 && !start_evt && !rx_stop && !trim_rise_i
    |=> s_q.count == $past(s_q.count) - 16'h0001)
    else $error("slow clock did not decrement");

  // Catches a leak from an unselected count clock
  a_unselected_quiet: assert property (
    running_o && !tick && !start_evt |=> $stable(s_q.count))
    else $error("count moved without its clock");

  c_tx_start: cover property (
    tx_end_i && s_q.start_select == RFT3_START_TX_END);
  c_auto_reload: cover property (uf && s_q.auto_reload_enable);
  c_rx_stop: cover property (rx_stop && running_o);
  c_one_shot_stop: cover property (uf && !s_q.auto_reload_enable);
  c_trim_window: cover property (
    trim_rise_i && trim_mode && !running_o ##[1:1000] trim_rise_i);

endmodule

// file: verification/rft3_timer_test.sv
// Self-checking bench for the reader front end timer three
module rft3_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rft3_pkg::*;

  logic        ref_clk_i = 1'h0;
  logic        srst_i    = 1'h1;
  logic [7:0]  addr_i    = 8'h00;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'h0;
  logic        rd_i      = 1'h0;
  logic [7:0]  in_q      = 8'h00; // Ticks 3:0, start, tx end, rx, trim
  logic [7:0]  rdata_o;
  logic        running_o;
  logic        underflow_o;
  logic        irq_o;
  logic [15:0] rl;
  integer      seed      = 32'hFFFF3F74;
  int          err_total;
  int          checks_done;
  int          cyc;

  rft3_timer dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tick_fast_i(in_q[0]), .tick_slow_i(in_q[1]),
    .timer_zero_uf_i(in_q[2]), .timer_one_uf_i(in_q[3]),
    .start_now_i(in_q[4]), .tx_end_i(in_q[5]),
    .rx_four_bits_i(in_q[6]), .trim_rise_i(in_q[7]),
    .running_o(running_o), .underflow_o(underflow_o),
    .underflow_irq_flag_o(irq_o)
  );

  // 20 MHz clock
  always #25 ref_clk_i = ~ref_clk_i;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'h1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i   <= 1'h1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'h0;
    #1 chk($sformatf("reg %h", a), {8'h00, rdata_o}, {8'h00, e});
  endtask

  // Bytes are sampled one at a time, so no ticks and no reception between
  task automatic cnt(input logic [15:0] e);
    rc(RFT3_OFS_COUNT_HI, e[15:8]);
    rc(RFT3_OFS_COUNT_LO, e[7:0]);
  endtask

  // One count tick; underflow same cycle, flag the cycle after
  task automatic tick(input int b, input logic u);
    @(posedge ref_clk_i);
    in_q[b] <= 1'h1;
    #1 chk("underflow", {15'h0, underflow_o}, {15'h0, u});
    @(posedge ref_clk_i);
    in_q[b] <= 1'h0;
    #1 chk("irq flag", {15'h0, irq_o}, {15'h0, u});
  endtask

  task automatic ev(input int b);
    @(posedge ref_clk_i);
    in_q[b] <= 1'h1;
    @(posedge ref_clk_i);
    in_q[b] <= 1'h0;
    #1;
  endtask

  task automatic run(input logic e);
    chk("running", {15'h0, running_o}, {15'h0, e});
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    rc(RFT3_OFS_CTRL, 8'h00);
    wr(RFT3_OFS_CTRL, 8'hFF);
    rc(RFT3_OFS_CTRL, 8'hBB);
    wr(RFT3_OFS_COUNT_HI, 8'hA5);
    wr(8'h23, 8'h5A);
    cnt(16'h0000);
    rc(8'h23, 8'h00);
    rl = 16'($random(seed));
    wr(RFT3_OFS_RELOAD_HI, rl[15:8]);
    wr(RFT3_OFS_RELOAD_LO, rl[7:0]);
    rc(RFT3_OFS_RELOAD_HI, rl[15:8]);
    rc(RFT3_OFS_RELOAD_LO, rl[7:0]);
    wr(RFT3_OFS_CTRL, 8'h18);
    ev(4);
    cnt(rl);
    // Short random reload, auto restart, start at transmit end
    rl = {14'h0, 2'($random(seed))} + 16'h1;
    wr(RFT3_OFS_RELOAD_HI, 8'h00);
    wr(RFT3_OFS_RELOAD_LO, rl[7:0]);
    ev(5);
    run(1'h1);
    cnt(rl);
    for (int i = 0; i < rl; i++) tick(0, 1'h0);
    tick(0, 1'h1);
    cnt(rl);
    run(1'h1);
    wr(RFT3_OFS_RELOAD_LO, 8'h09);
    tick(0, 1'h0);
    cnt(rl - 16'h1);
    // One-shot on the slow clock
    wr(RFT3_OFS_CTRL, 8'h11);
    ev(4);
    cnt(16'h0009);
    for (int i = 0; i < 9; i++) tick(1, 1'h0);
    tick(1, 1'h1);
    run(1'h0);
    tick(1, 1'h0);
    cnt(16'h0000);
    // Only the selected source may count
    for (int c = 0; c < 4; c++) begin
      wr(RFT3_OFS_CTRL, 8'h10 | 8'(c));
      ev(4);
      for (int b = 0; b < 4; b++) tick(b, 1'h0);
      cnt(16'h0008);
    end
    // Stop on receive, then start modes
    ev(6);
    run(1'h1);
    wr(RFT3_OFS_CTRL, 8'h90);
    ev(4);
    ev(6);
    run(1'h0);
    tick(0, 1'h0);
    cnt(16'h0009);
    wr(RFT3_OFS_CTRL, 8'h00);
    ev(5);
    run(1'h0);
    wr(RFT3_OFS_CTRL, 8'hA0);
    wr(RFT3_OFS_RELOAD_LO, 8'h01);
    ev(7);
    run(1'h1);
    ev(6);
    run(1'h1);
    tick(0, 1'h0);
    tick(0, 1'h0);
    ev(7);
    run(1'h0);
    wr(RFT3_OFS_CTRL, 8'hB0);
    ev(7);
    tick(0, 1'h0);
    tick(0, 1'h1);
    end_of_test();
  end
endmodule
